// [logic/pcics_flags.sv]
// Sticky status flags that hardware sets and software clears by writing one.
`timescale 1ns/1ps
module pcics_flags #(
    parameter int WIDTH = 5
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flags_out
);
    // One flag per bit; a set in the clearing cycle wins so no event is lost.
    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
        logic flag_reg;
        logic flag_next;
        assign flag_next = set_in[i] | (flag_reg & ~clr_in[i]);
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                flag_reg <= 1'b0;
            end else begin
                flag_reg <= flag_next;
            end
        end
        assign flags_out[i] = flag_reg;
    end
endmodule : pcics_flags

// [logic/pcics_ident.sv]
// Identification word captured from the serial EEPROM loader.
`timescale 1ns/1ps
module pcics_ident (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic [15:0] device_id_in,
    input wire logic [15:0] vendor_id_in,
    output logic [31:0] ident_out
);
    import pcics_pkg::*;

    logic [31:0] ident_reg;
    logic [31:0] ident_next;

    // Device identifier in the upper half, vendor identifier in the lower half.
    assign ident_next = load_in ? {device_id_in, vendor_id_in} : ident_reg;

    // The word only changes on a loader strobe; the host cannot write it.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ident_reg <= PCICS_ID_RESET;
        end else begin
            ident_reg <= ident_next;
        end
    end

    assign ident_out = ident_reg;
endmodule : pcics_ident

// [logic/pcics_pkg.sv]
// Package with offsets, field positions, reset values and carrier types of the config block.
package pcics_pkg;
    // Byte offsets of the two configuration words.
    localparam logic [7:0] PCICS_OFS_ID = 8'h00;
    localparam logic [7:0] PCICS_OFS_CMDSTAT = 8'h04;
    // Field positions of the command and status word.
    localparam int PCICS_BIT_PERR_DET = 31;
    localparam int PCICS_BIT_SERR_SIG = 30;
    localparam int PCICS_BIT_MABORT = 29;
    localparam int PCICS_BIT_TABORT = 28;
    localparam int PCICS_BIT_DEVSEL_LO = 25;
    localparam int PCICS_BIT_DPR = 24;
    localparam int PCICS_BIT_FB2B = 23;
    localparam int PCICS_BIT_NEWCAP = 20;
    localparam int PCICS_BIT_SERR_EN = 8;
    localparam int PCICS_BIT_PERR_EN = 6;
    localparam int PCICS_BIT_BM_EN = 2;
    localparam int PCICS_BIT_MEM_EN = 1;
    localparam int PCICS_BIT_IO_DIS = 0;
    // Position of the capability source bit in the internal control register.
    localparam int PCICS_BIT_CAP_SRC = 19;
    // Position of the fatal system error bit in the interrupt status register.
    localparam int PCICS_BIT_FATAL = 13;
    // Fixed and reset values.
    localparam logic [1:0] PCICS_DEVSEL_MEDIUM = 2'h1;
    localparam logic PCICS_FB2B_VALUE = 1'h1;
    localparam logic PCICS_CMD_RESET = 1'h0;
    localparam logic [31:0] PCICS_ID_RESET = 32'h0000_0000;
    localparam logic [31:0] PCICS_READ_ZERO = 32'h0000_0000;
    // Sticky status flag indices.
    localparam int PCICS_NFLAGS = 5;
    localparam int PCICS_FLG_PERR = 0;
    localparam int PCICS_FLG_SERR = 1;
    localparam int PCICS_FLG_MABT = 2;
    localparam int PCICS_FLG_TABT = 3;
    localparam int PCICS_FLG_DPR = 4;

    // One configuration access from the host side.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcics_cfg_req_s;

    // Bus events reported by the PCI engine on the same clock.
    typedef struct packed {
        logic addr_parity_err;
        logic data_parity_err;
        logic perr_seen;
        logic master_abort;
        logic target_abort;
        logic master_active;
        logic master_req;
    } pcics_evt_s;
endpackage : pcics_pkg

// [logic/pcics_regs.sv]
// Identification, command and status configuration words of the PCI controller.
// Summary of operation
// - Word zero holds device ID high, vendor ID low, read-only, from EEPROM.
// - Any detected parity error sets its status bit, whatever parity response says.
// - Driving system error sets the system-error status bit.
// - A master abort ends the master transaction and sets its status bit.
// - A target abort ends the master transaction and sets its status bit.
// - Select-timing field reads 01; target cycles are claimed with medium timing.
// - Data-parity-reported sets only as master, parity response on, PERR driven or seen.
// - Fast back-to-back capable reads one; such target cycles are accepted.
// - New-capabilities bit mirrors bit 19 of the internal control register.
// - System error is driven on address parity error only when enabled.
// - Parity response off, the reset value, means parity errors cause no action; system error is still driven on address parity error while its enable is set.
// - Parity response on raises the fatal system-error flag on each parity error.
// - No master transfers while bus-master enable, reset zero, is clear.
// - Memory space accesses answered only while memory enable is one; resets zero.
// - I/O control bit is inverted: zero enables I/O decode; resets zero.
`timescale 1ns/1ps
module pcics_regs (
    input wire logic clk_in,
    input wire logic resetn_in,
    input pcics_pkg::pcics_cfg_req_s cfg_req_in,
    input pcics_pkg::pcics_evt_s evt_in,
    input wire logic id_load_in,
    input wire logic [15:0] id_device_in,
    input wire logic [15:0] id_vendor_in,
    input wire logic [31:0] internal_ctrl_in,
    input wire logic mem_hit_in,
    output logic cfg_ack_out,
    output logic [31:0] cfg_rdata_out,
    output logic serr_drive_out,
    output logic perr_drive_out,
    output logic fatal_sys_err_out,
    output logic master_terminate_out,
    output logic master_req_out,
    output logic mem_claim_out,
    output logic mem_space_en_out,
    output logic io_space_en_out,
    output logic bus_master_en_out,
    output logic [1:0] devsel_timing_out,
    output logic fast_b2b_accept_out
);
    import pcics_pkg::*;

    logic serr_en_reg;
    logic perr_en_reg;
    logic bm_en_reg;
    logic mem_en_reg;
    logic io_dis_reg;
    logic serr_en_next;
    logic perr_en_next;
    logic bm_en_next;
    logic mem_en_next;
    logic io_dis_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic serr_reg;
    logic perr_reg;
    logic fatal_reg;
    logic term_reg;
    logic mreq_reg;
    logic claim_reg;
    logic mem_out_reg;
    logic io_out_reg;
    logic bm_out_reg;
    logic [1:0] devsel_reg;
    logic fb2b_reg;
    logic [31:0] ident_w;
    logic [PCICS_NFLAGS-1:0] flags_w;
    logic [PCICS_NFLAGS-1:0] flag_set_w;
    logic [PCICS_NFLAGS-1:0] flag_clr_w;
    logic [31:0] cmdstat_w;
    logic [31:0] rdata_next;

    // Address decode of a configuration access.
    wire hit_id = cfg_req_in.valid && (cfg_req_in.addr == PCICS_OFS_ID);
    wire hit_cmd = cfg_req_in.valid && (cfg_req_in.addr == PCICS_OFS_CMDSTAT);
    wire wr_lo = hit_cmd && cfg_req_in.write && cfg_req_in.be[0];
    wire wr_hi = hit_cmd && cfg_req_in.write && cfg_req_in.be[1];
    wire wr_st = hit_cmd && cfg_req_in.write && cfg_req_in.be[3];

    // Parity and system error reactions of this cycle.
    // enable-gated system error
    wire serr_now = evt_in.addr_parity_err && serr_en_reg;
    wire perr_now = evt_in.data_parity_err && perr_en_reg;
    wire any_parity = evt_in.addr_parity_err || evt_in.data_parity_err;
    wire abort_now = evt_in.master_abort || evt_in.target_abort;

    // Command bits take byte lane writes; other bits in those lanes are ignored.
    // reserved writes ignored
    assign serr_en_next = wr_hi ? cfg_req_in.wdata[PCICS_BIT_SERR_EN] : serr_en_reg;
    assign perr_en_next = wr_lo ? cfg_req_in.wdata[PCICS_BIT_PERR_EN] : perr_en_reg;
    assign bm_en_next = wr_lo ? cfg_req_in.wdata[PCICS_BIT_BM_EN] : bm_en_reg;
    assign mem_en_next = wr_lo ? cfg_req_in.wdata[PCICS_BIT_MEM_EN] : mem_en_reg;
    assign io_dis_next = wr_lo ? cfg_req_in.wdata[PCICS_BIT_IO_DIS] : io_dis_reg;

    // Status flag set sources.
    // parity detected always
    assign flag_set_w[PCICS_FLG_PERR] = any_parity;
    assign flag_set_w[PCICS_FLG_SERR] = serr_now;
    assign flag_set_w[PCICS_FLG_MABT] = evt_in.master_abort;
    assign flag_set_w[PCICS_FLG_TABT] = evt_in.target_abort;
    assign flag_set_w[PCICS_FLG_DPR] = evt_in.master_active && perr_en_reg &&
                                       (perr_now || evt_in.perr_seen);

    // Write-one-to-clear on the upper status byte.
    // write one clears
    assign flag_clr_w[PCICS_FLG_PERR] = wr_st && cfg_req_in.wdata[PCICS_BIT_PERR_DET];
    assign flag_clr_w[PCICS_FLG_SERR] = wr_st && cfg_req_in.wdata[PCICS_BIT_SERR_SIG];
    assign flag_clr_w[PCICS_FLG_MABT] = wr_st && cfg_req_in.wdata[PCICS_BIT_MABORT];
    assign flag_clr_w[PCICS_FLG_TABT] = wr_st && cfg_req_in.wdata[PCICS_BIT_TABORT];
    assign flag_clr_w[PCICS_FLG_DPR] = wr_st && cfg_req_in.wdata[PCICS_BIT_DPR];

    // Sticky status flags.
    pcics_flags #(
        .WIDTH(PCICS_NFLAGS)
    ) u_flags (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .set_in(flag_set_w),
        .clr_in(flag_clr_w),
        .flags_out(flags_w)
    );

    pcics_ident u_ident (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .load_in(id_load_in),
        .device_id_in(id_device_in),
        .vendor_id_in(id_vendor_in),
        .ident_out(ident_w)
    );

    // Read view of the command and status word; unlisted bits stay zero.
    // reserved reads zero
    always_comb begin
        cmdstat_w = PCICS_READ_ZERO;
        cmdstat_w[PCICS_BIT_PERR_DET] = flags_w[PCICS_FLG_PERR];
        cmdstat_w[PCICS_BIT_SERR_SIG] = flags_w[PCICS_FLG_SERR];
        cmdstat_w[PCICS_BIT_MABORT] = flags_w[PCICS_FLG_MABT];
        cmdstat_w[PCICS_BIT_TABORT] = flags_w[PCICS_FLG_TABT];
        cmdstat_w[PCICS_BIT_DEVSEL_LO+1:PCICS_BIT_DEVSEL_LO] = PCICS_DEVSEL_MEDIUM;
        cmdstat_w[PCICS_BIT_DPR] = flags_w[PCICS_FLG_DPR];
        cmdstat_w[PCICS_BIT_FB2B] = PCICS_FB2B_VALUE;
        cmdstat_w[PCICS_BIT_NEWCAP] = internal_ctrl_in[PCICS_BIT_CAP_SRC];
        cmdstat_w[PCICS_BIT_SERR_EN] = serr_en_reg;
        cmdstat_w[PCICS_BIT_PERR_EN] = perr_en_reg;
        cmdstat_w[PCICS_BIT_BM_EN] = bm_en_reg;
        cmdstat_w[PCICS_BIT_MEM_EN] = mem_en_reg;
        cmdstat_w[PCICS_BIT_IO_DIS] = io_dis_reg;
    end

    // Read data select; unmapped offsets answer with zero.
    assign rdata_next = (cfg_req_in.valid && !cfg_req_in.write) ?
                        (hit_id ? ident_w : (hit_cmd ? cmdstat_w : PCICS_READ_ZERO)) :
                        PCICS_READ_ZERO;

    // Command register bits.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            serr_en_reg <= PCICS_CMD_RESET;
            perr_en_reg <= PCICS_CMD_RESET;
            bm_en_reg <= PCICS_CMD_RESET;
            mem_en_reg <= PCICS_CMD_RESET;
            io_dis_reg <= PCICS_CMD_RESET;
        end else begin
            serr_en_reg <= serr_en_next;
            perr_en_reg <= perr_en_next;
            bm_en_reg <= bm_en_next;
            mem_en_reg <= mem_en_next;
            io_dis_reg <= io_dis_next;
        end
    end

    // Configuration answer, one cycle after the request.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_reg <= 1'b0;
            rdata_reg <= PCICS_READ_ZERO;
        end else begin
            ack_reg <= cfg_req_in.valid;
            rdata_reg <= rdata_next;
        end
    end

    // Error signalling and master termination towards the bus engine.
    // fatal flag on parity
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            serr_reg <= 1'b0;
            perr_reg <= 1'b0;
            fatal_reg <= 1'b0;
            term_reg <= 1'b0;
        end else begin
            serr_reg <= serr_now;
            perr_reg <= perr_now;
            fatal_reg <= any_parity && perr_en_reg;
            term_reg <= abort_now;
        end
    end

    // Space decode enables and master gating, registered for the outputs.
    // master gated by enable
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mreq_reg <= 1'b0;
            claim_reg <= 1'b0;
            mem_out_reg <= 1'b0;
            io_out_reg <= 1'b0;
            bm_out_reg <= 1'b0;
            devsel_reg <= PCICS_DEVSEL_MEDIUM;
            fb2b_reg <= PCICS_FB2B_VALUE;
        end else begin
            mreq_reg <= evt_in.master_req && bm_en_reg;
            claim_reg <= mem_hit_in && mem_en_reg;
            mem_out_reg <= mem_en_reg;
            io_out_reg <= !io_dis_reg;
            bm_out_reg <= bm_en_reg;
            devsel_reg <= PCICS_DEVSEL_MEDIUM;
            fb2b_reg <= PCICS_FB2B_VALUE;
        end
    end

    assign cfg_ack_out = ack_reg;
    assign cfg_rdata_out = rdata_reg;
    assign serr_drive_out = serr_reg;
    assign perr_drive_out = perr_reg;
    assign fatal_sys_err_out = fatal_reg;
    assign master_terminate_out = term_reg;
    assign master_req_out = mreq_reg;
    assign mem_claim_out = claim_reg;
    assign mem_space_en_out = mem_out_reg;
    assign io_space_en_out = io_out_reg;
    assign bus_master_en_out = bm_out_reg;
    assign devsel_timing_out = devsel_reg;
    assign fast_b2b_accept_out = fb2b_reg;

    perr_status_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        evt_in.data_parity_err |=> flags_w[PCICS_FLG_PERR])
        else $error("parity status not set");

    serr_status_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        serr_drive_out |-> flags_w[PCICS_FLG_SERR])
        else $error("system error status missing");

    mabort_term_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        evt_in.master_abort |=> master_terminate_out && flags_w[PCICS_FLG_MABT])
        else $error("master abort not handled");

    devsel_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cfg_req_in.valid && !cfg_req_in.write && hit_cmd |=>
        cfg_rdata_out[26:25] == 2'h1 && cfg_rdata_out[23] && cfg_rdata_out[27] == 1'b0)
        else $error("fixed status fields wrong");

    dpr_cause_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(flags_w[PCICS_FLG_DPR]) |-> $past(evt_in.master_active) && $past(perr_en_reg))
        else $error("parity report without cause");

    serr_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        serr_drive_out |-> $past(evt_in.addr_parity_err) && $past(serr_en_reg))
        else $error("system error without enable");

    fatal_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        any_parity && perr_en_reg |=> fatal_sys_err_out)
        else $error("fatal flag not raised");

    master_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !bm_en_reg ##1 !bm_en_reg |-> !master_req_out)
        else $error("master request while disabled");

    w1c_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_st && cfg_req_in.wdata[PCICS_BIT_MABORT] && !evt_in.master_abort |=>
        !flags_w[PCICS_FLG_MABT])
        else $error("status bit not cleared");

    tabort_term_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        evt_in.target_abort |=> master_terminate_out && flags_w[PCICS_FLG_TABT])
        else $error("target abort not handled");

    mem_claim_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mem_claim_out |-> $past(mem_hit_in) && $past(mem_en_reg))
        else $error("memory claim while disabled");

    perr_quiet_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !perr_en_reg |=> !perr_drive_out && !fatal_sys_err_out)
        else $error("parity action while disabled");
endmodule : pcics_regs

// [test/pcics_host_model.sv]
// Host model that issues configuration reads and writes to the config block.
`timescale 1ns/1ps
module pcics_host_model (
    input wire logic clk_in,
    input wire logic cfg_ack_in,
    input wire logic [31:0] cfg_rdata_in,
    output pcics_pkg::pcics_cfg_req_s cfg_req_out
);
    import pcics_pkg::*;
    // The bus starts idle with no request.
    initial begin
        cfg_req_out = '0;
    end
    // One access is driven after a falling edge; its answer is registered on the edge that takes it and sampled at the next falling edge.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata, output logic ack, output logic [31:0] rdata);
        @(negedge clk_in);
        cfg_req_out <= '{valid: 1'b1, write: wr, addr: addr, be: be, wdata: wdata};
        @(negedge clk_in);
        ack = cfg_ack_in;
        rdata = cfg_rdata_in;
        // Released lines show the inverse of the last value so stale data never matches.
        cfg_req_out <= '{valid: 1'b0, write: ~wr, addr: ~addr, be: ~be, wdata: ~wdata};
    endtask : access
endmodule : pcics_host_model

// [test/tb_pcics_regs.sv]
// Self-checking bench for the identification, command and status words.
`timescale 1ns/1ps
module tb_pcics_regs;
    import pcics_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    pcics_evt_s evt = '0;
    logic id_load = 1'b0;
    logic [15:0] id_dev = 16'h0000;
    logic [15:0] id_ven = 16'h0000;
    logic [31:0] ictl = 32'h0000_0000;
    logic mem_hit = 1'b0;
    pcics_cfg_req_s req;
    logic ack, serr, perr, fatal, mterm, mreq, mclaim, mem_en, io_en, bm_en, fb2b;
    logic [1:0] dst;
    logic [31:0] rdata;
    int miscompares = 0;
    int n_compared = 0;
    // Fixed status content: select timing 01 and fast back-to-back one.
    localparam logic [31:0] FIX = 32'h0280_0000;
    localparam logic [7:0] CS = PCICS_OFS_CMDSTAT;
    // Arbitrary identification values of our own making.
    localparam logic [15:0] DEV_ID = 16'hC3A5;
    localparam logic [15:0] VEN_ID = 16'h5A1E;

    // The clock toggles every half period of 4 ns.
    always #4 clk_in = ~clk_in;

    pcics_regs u_pcics_regs (.clk_in(clk_in), .resetn_in(resetn_in), .cfg_req_in(req),
        .evt_in(evt), .id_load_in(id_load), .id_device_in(id_dev), .id_vendor_in(id_ven),
        .internal_ctrl_in(ictl), .mem_hit_in(mem_hit), .cfg_ack_out(ack),
        .cfg_rdata_out(rdata), .serr_drive_out(serr), .perr_drive_out(perr),
        .fatal_sys_err_out(fatal), .master_terminate_out(mterm), .master_req_out(mreq),
        .mem_claim_out(mclaim), .mem_space_en_out(mem_en), .io_space_en_out(io_en),
        .bus_master_en_out(bm_en), .devsel_timing_out(dst), .fast_b2b_accept_out(fb2b));

    pcics_host_model u_pcics_host_model (.clk_in(clk_in), .cfg_ack_in(ack),
        .cfg_rdata_in(rdata), .cfg_req_out(req));

    // Compares one value and counts it.
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Reads a word and expects an acknowledge with the given data.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic k;
        logic [31:0] d;
        u_pcics_host_model.access(1'b0, a, 4'h0, 32'h0000_0000, k, d);
        chk({k, d}, {1'b1, exp});
    endtask : rd

    // Writes a word and expects an acknowledge.
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic k;
        logic [31:0] r;
        u_pcics_host_model.access(1'b1, a, be, d, k, r);
        chk({32'h0000_0000, k}, 33'h0_0000_0001);
    endtask : wr

    // Raises events for one cycle and checks serr, perr, fatal and terminate pulses.
    task automatic pulse(input pcics_evt_s e, input logic [3:0] exp);
        @(negedge clk_in);
        evt <= e;
        @(negedge clk_in);
        chk({serr, perr, fatal, mterm}, exp);
        evt <= '0;
    endtask : pulse

    task automatic t_reset();
        chk({dst, fb2b, mem_en, io_en, bm_en, mreq}, 7'h34);
        rd(CS, FIX);
        rd(PCICS_OFS_ID, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
    endtask : t_reset

    task automatic t_ident();
        @(negedge clk_in);
        id_dev <= DEV_ID;
        id_ven <= VEN_ID;
        id_load <= 1'b1;
        @(negedge clk_in);
        id_load <= 1'b0;
        id_dev <= ~DEV_ID;
        id_ven <= ~VEN_ID;
        rd(PCICS_OFS_ID, {DEV_ID, VEN_ID});
        wr(PCICS_OFS_ID, 4'hF, 32'hFFFF_FFFF);
        rd(PCICS_OFS_ID, {DEV_ID, VEN_ID});
        ictl <= 32'h0008_0000;
        rd(CS, FIX | 32'h0010_0000);
        ictl <= 32'hFFF7_FFFF;
        rd(CS, FIX);
        ictl <= 32'h0000_0000;
    endtask : t_ident

    task automatic t_cmd();
        wr(CS, 4'hF, 32'h0E7F_FFFF);
        rd(CS, FIX | 32'h0000_0147);
        @(negedge clk_in);
        mem_hit <= 1'b1;
        evt <= '{master_req: 1'b1, default: 1'b0};
        @(negedge clk_in);
        chk({mclaim, mreq, mem_en, io_en, bm_en}, 5'h1D);
        wr(CS, 4'h1, 32'h0000_0000);
        @(negedge clk_in);
        chk({mclaim, mreq, mem_en, io_en, bm_en}, 5'h02);
        mem_hit <= 1'b0;
        evt <= '0;
        wr(CS, 4'h2, 32'h0000_0000);
        rd(CS, FIX);
    endtask : t_cmd

    // Parity handling with and without responses.
    task automatic t_parity();
        pulse('{addr_parity_err: 1'b1, default: 1'b0}, 4'h0);
        rd(CS, FIX | 32'h8000_0000);
        wr(CS, 4'h8, 32'h0000_0000);
        rd(CS, FIX | 32'h8000_0000);
        wr(CS, 4'h8, 32'h8000_0000);
        rd(CS, FIX);
        wr(CS, 4'h3, 32'h0000_0140);
        pulse('{addr_parity_err: 1'b1, default: 1'b0}, 4'hA);
        rd(CS, FIX | 32'hC000_0140);
        wr(CS, 4'h8, 32'hC000_0000);
        pulse('{data_parity_err: 1'b1, default: 1'b0}, 4'h6);
        rd(CS, FIX | 32'h8000_0140);
        pulse('{data_parity_err: 1'b1, master_active: 1'b1, default: 1'b0}, 4'h6);
        rd(CS, FIX | 32'h8100_0140);
        wr(CS, 4'hB, 32'hFF00_0000);
        pulse('{data_parity_err: 1'b1, master_active: 1'b1, default: 1'b0}, 4'h0);
        rd(CS, FIX | 32'h8000_0000);
        wr(CS, 4'h8, 32'hFF00_0000);
    endtask : t_parity

    // Aborts terminate the transfer and set status.
    task automatic t_abort();
        pulse('{master_abort: 1'b1, default: 1'b0}, 4'h1);
        rd(CS, FIX | 32'h2000_0000);
        pulse('{target_abort: 1'b1, default: 1'b0}, 4'h1);
        rd(CS, FIX | 32'h3000_0000);
        wr(CS, 4'h8, 32'h1000_0000);
        rd(CS, FIX | 32'h2000_0000);
    endtask : t_abort

    // A reset in mid-run restores the command and status defaults.
    task automatic t_midreset();
        wr(CS, 4'h3, 32'h0000_0147);
        @(negedge clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(negedge clk_in);
        chk({dst, fb2b, mem_en, io_en, bm_en, mreq, mterm}, 8'h68);
        rd(CS, FIX);
        rd(PCICS_OFS_ID, 32'h0000_0000);
    endtask : t_midreset

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence: reset for six cycles, then every scenario in turn.
    initial begin
        repeat (6) @(negedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(negedge clk_in);
        t_reset();
        t_ident();
        t_cmd();
        t_parity();
        t_abort();
        t_midreset();
        report_and_stop();
    end

    // Watchdog well beyond the roughly 100 cycles the scenarios need.
    initial begin
        #(8 * 3000);
        miscompares++;
        report_and_stop();
    end
endmodule : tb_pcics_regs
